// [nand_program_sequencer.sv]
// host side sequencer for nand program, copy-back and cache program
// assumes one ahb-lite master and a nand die on the pins below
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module nand_program_sequencer import nand_host_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output nand_pins_s nand_pins,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n_pin
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_POLL_CMD, S_POLL_RD, S_CMD1, S_ADDR, S_DATA, S_CONF,
    S_TWB, S_WAIT_RB, S_BUF_RD
  } state_e;
  state_e state_q;
  op_e op_q;
  logic second_q, alt_q, last_q, plane_q, poll_q, err_q, cache_open_q;
  logic pend_q, go_q, consume_q, wfull_q, rvalid_q, wen_q;
  logic [LEN_W-1:0] cnt_q, len_q;
  logic [ADDR_W-1:0] addr0_q, addr1_q, cur_addr;
  logic [ADDR_W-1:PAIR_LSB] pair_q;
  logic [7:0] waddr_q, wdata_q, rdata_q, stat_q, wbyte_q, abyte, rbyte;
  logic [7:0] first_cmd, conf_cmd;
  cyc_e kind_q;
  logic [2:0] n_addr, addr_idx;
  logic eng_done, mp, cache, has_data, start, new_cache, mismatch, pop;
  op_e new_op;

  nand_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(go_q),
    .kind(kind_q),
    .wbyte(wbyte_q),
    .io_in(io_in),
    .pins(nand_pins),
    .rbyte(rbyte),
    .done(eng_done)
  );

  // ***************************************************************
  // sequence decode
  // ***************************************************************
  always_comb begin
    mp = op_q inside {OP_MP_PROG, OP_MP_CACHE, OP_MP_CB_PROG};
    cache = op_q inside {OP_CACHE, OP_MP_CACHE};
    has_data = op_q inside {OP_PROG, OP_MP_PROG, OP_CACHE, OP_MP_CACHE,
                            OP_CB_PROG, OP_MP_CB_PROG};
    cur_addr = second_q ? addr1_q : addr0_q;
    if (mp) begin
      cur_addr[PLANE_BIT] = second_q;
    end else if (op_q == OP_CB_READ) begin
      cur_addr[PLANE_BIT] = plane_q;
    end
    n_addr = (op_q == OP_STATUS_ENH) ? ROW_CYCLES : ADDR_CYCLES;
    addr_idx = (op_q == OP_STATUS_ENH) ? cnt_q[2:0] + COL_CYCLES
                                       : cnt_q[2:0];
    abyte = 8'(cur_addr >> {addr_idx, 3'h0});
    case (op_q)
      OP_CB_READ: first_cmd = CMD_READ;
      OP_CB_PROG: first_cmd = CMD_CB_LOAD;
      OP_MP_CB_PROG: first_cmd = !second_q ? CMD_CB_LOAD :
                                 alt_q ? CMD_CB_LOAD : CMD_LOAD2;
      OP_STATUS_ENH: first_cmd = CMD_STATUS_ENH;
      default: first_cmd = (second_q && !alt_q) ? CMD_LOAD2 : CMD_LOAD;
    endcase
    // dummy between planes, 15h or final 10h
    if (op_q == OP_CB_READ) begin
      conf_cmd = CMD_CB_READ;
    end else if (mp && !second_q) begin
      conf_cmd = CMD_DUMMY;
    end else if (cache && !last_q) begin
      conf_cmd = CMD_CACHE;
    end else begin
      conf_cmd = CMD_CONFIRM;
    end
    start = wen_q && (waddr_q == REG_CTRL);
    new_op = op_e'(hwdata[3:0]);
    new_cache = new_op inside {OP_CACHE, OP_MP_CACHE};
    // one block pair per cache run
    mismatch = new_cache &&
      ((cache_open_q && addr0_q[ADDR_W-1:PAIR_LSB] != pair_q) ||
       (new_op == OP_MP_CACHE &&
        addr1_q[ADDR_W-1:PAIR_LSB] != addr0_q[ADDR_W-1:PAIR_LSB]));
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      op_q <= OP_NONE;
      {second_q, alt_q, last_q, plane_q, poll_q, err_q} <= 6'h00;
      {cache_open_q, pend_q, go_q, consume_q} <= 4'h0;
      cnt_q <= '0;
      pair_q <= '0;
      kind_q <= CY_CMD;
      wbyte_q <= 8'h00;
      stat_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      go_q <= 1'b0;
      consume_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start && new_op != OP_NONE && new_op <= OP_BUF_READ) begin
            op_q <= new_op;
            alt_q <= hwdata[CTRL_ALT];
            last_q <= hwdata[CTRL_LAST];
            plane_q <= hwdata[CTRL_PLANE];
            second_q <= 1'b0;
            cnt_q <= '0;
            err_q <= mismatch;
            if (new_cache && !cache_open_q) begin
              pair_q <= addr0_q[ADDR_W-1:PAIR_LSB];
            end
            if (mismatch) begin
              state_q <= S_IDLE;
            end else if (cache_open_q && !new_cache) begin
              // array must finish before another operation
              poll_q <= 1'b1;
              state_q <= S_POLL_CMD;
            end else if (new_op == OP_STATUS) begin
              state_q <= S_POLL_CMD;
            end else if (new_op == OP_BUF_READ) begin
              state_q <= S_BUF_RD;
            end else begin
              state_q <= S_CMD1;
            end
          end
        end
        S_POLL_CMD: begin
          if (!pend_q) begin
            {go_q, pend_q, kind_q, wbyte_q} <= {2'h3, CY_CMD, CMD_STATUS};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            state_q <= S_POLL_RD;
          end
        end
        S_POLL_RD: begin
          if (!pend_q) begin
            {go_q, pend_q, kind_q} <= {2'h3, CY_DOUT};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            stat_q <= rbyte;
            if (!poll_q) begin
              state_q <= S_IDLE;
            end else if (rbyte[SR_ARRAY_RDY]) begin
              // bit 5 seen, operation may go on
              poll_q <= 1'b0;
              cache_open_q <= 1'b0;
              state_q <= (op_q == OP_BUF_READ) ? S_BUF_RD :
                         (op_q == OP_STATUS) ? S_IDLE : S_CMD1;
            end
          end
        end
        S_CMD1: begin
          if (!pend_q) begin
            {go_q, pend_q, kind_q, wbyte_q} <= {2'h3, CY_CMD, first_cmd};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            cnt_q <= '0;
            state_q <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (!pend_q) begin
            {go_q, pend_q, kind_q, wbyte_q} <= {2'h3, CY_ADDR, abyte};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            if (cnt_q[2:0] == n_addr - 3'h1) begin
              cnt_q <= '0;
              state_q <= (op_q == OP_STATUS_ENH) ? S_POLL_RD :
                         has_data ? S_DATA : S_CONF;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        S_DATA: begin
          if (!pend_q && cnt_q == len_q) begin
            state_q <= S_CONF;
          end else if (!pend_q && wfull_q) begin
            {go_q, pend_q, kind_q, wbyte_q} <= {2'h3, CY_DIN, wdata_q};
            consume_q <= 1'b1;
          end else if (eng_done) begin
            pend_q <= 1'b0;
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_CONF: begin
          if (!pend_q) begin
            {go_q, pend_q, kind_q, wbyte_q} <= {2'h3, CY_CMD, conf_cmd};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            cnt_q <= '0;
            state_q <= S_TWB;
          end
        end
        S_TWB: begin
          if (cnt_q == LEN_W'(TWB_CYC - 1)) begin
            state_q <= S_WAIT_RB;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_WAIT_RB: begin
          if (ready_busy_n_pin) begin
            cnt_q <= '0;
            if (mp && !second_q) begin
              second_q <= 1'b1;
              state_q <= S_CMD1;
            end else if (op_q == OP_CB_READ) begin
              state_q <= S_IDLE;
            end else if (cache && !last_q) begin
              cache_open_q <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              cache_open_q <= 1'b0;
              state_q <= S_POLL_CMD;
            end
          end
        end
        S_BUF_RD: begin
          // optional buffer readout after copy-back read
          if (!pend_q && cnt_q == len_q) begin
            state_q <= S_IDLE;
          end else if (!pend_q && !rvalid_q) begin
            {go_q, pend_q, kind_q} <= {2'h3, CY_DOUT};
          end else if (eng_done) begin
            pend_q <= 1'b0;
            rdata_q <= rbyte;
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // data handshake flags
  // ***************************************************************
  // a set in the same cycle as a clear wins, so no byte is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wfull_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      if (wen_q && waddr_q == REG_WDATA) begin
        wfull_q <= 1'b1;
      end else if (consume_q) begin
        wfull_q <= 1'b0;
      end
      if (eng_done && state_q == S_BUF_RD) begin
        rvalid_q <= 1'b1;
      end else if (pop) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // ahb-lite slave, zero wait states
  // ***************************************************************
  // only haddr[7:0] is decoded, so the map aliases above 256 bytes
  assign pop = hsel && htrans[1] && hready && !hwrite &&
               haddr[7:0] == REG_RDATA;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wen_q <= hsel && htrans[1] && hready && hwrite;
      waddr_q <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          REG_CTRL: hrdata <= {28'h0, op_q};
          REG_ADDR0_LO: hrdata <= addr0_q[31:0];
          REG_ADDR0_HI: hrdata <= {24'h0, addr0_q[ADDR_W-1:32]};
          REG_ADDR1_LO: hrdata <= addr1_q[31:0];
          REG_ADDR1_HI: hrdata <= {24'h0, addr1_q[ADDR_W-1:32]};
          REG_LEN: hrdata <= {19'h0, len_q};
          REG_RDATA: hrdata <= {24'h0, rdata_q};
          REG_STATUS: begin
            hrdata <= 32'h0000_0000;
            hrdata[ST_BUSY] <= (state_q != S_IDLE);
            // a byte in flight counts, so no surplus byte is asked for
            hrdata[ST_DREQ] <= (state_q == S_DATA) && !wfull_q &&
                               (cnt_q + LEN_W'(pend_q)) != len_q;
            hrdata[ST_RVALID] <= rvalid_q;
            hrdata[ST_ERR] <= err_q;
            hrdata[ST_RB] <= ready_busy_n_pin;
            hrdata[ST_CACHE] <= cache_open_q;
            hrdata[ST_SR_LSB +: 8] <= stat_q;
          end
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr0_q <= '0;
      addr1_q <= '0;
      len_q <= '0;
      wdata_q <= 8'h00;
    end else if (wen_q) begin
      case (waddr_q)
        REG_ADDR0_LO: addr0_q[31:0] <= hwdata;
        REG_ADDR0_HI: addr0_q[ADDR_W-1:32] <= hwdata[7:0];
        REG_ADDR1_LO: addr1_q[31:0] <= hwdata;
        REG_ADDR1_HI: addr1_q[ADDR_W-1:32] <= hwdata[7:0];
        REG_LEN: len_q <= hwdata[LEN_W-1:0];
        REG_WDATA: wdata_q <= hwdata[7:0];
        default: len_q <= len_q;
      endcase
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  first_load_a: assert property (
    state_q == S_CMD1 && go_q && !second_q &&
    op_q inside {OP_MP_PROG, OP_MP_CACHE} |-> wbyte_q == CMD_LOAD)
    else $error("first plane load not 80h");
  // plane bit zero on first page
  plane_zero_a: assert property (
    go_q && state_q == S_ADDR && mp && !second_q && cnt_q == 2 |->
    !wbyte_q[PLANE_BIT - 16])
    else $error("first plane address has plane bit set");
  // plane bit one on second page
  plane_one_a: assert property (
    go_q && state_q == S_ADDR && mp && second_q && cnt_q == 2 |->
    wbyte_q[PLANE_BIT - 16])
    else $error("second plane address has plane bit clear");
  second_ready_a: assert property (
    $rose(second_q) |-> $past(ready_busy_n_pin) ##1 state_q == S_CMD1)
    else $error("second plane started while busy");
  dummy_conf_a: assert property (
    go_q && state_q == S_CONF && mp && !second_q |->
    wbyte_q == CMD_DUMMY)
    else $error("plane one not closed by 11h");
  last_conf_a: assert property (
    go_q && state_q == S_CONF && cache && last_q &&
    (second_q || !mp) |-> wbyte_q == CMD_CONFIRM)
    else $error("last cache page not confirmed by 10h");
  poll_first_a: assert property (
    state_q == S_IDLE && start && cache_open_q && !new_cache &&
    new_op inside {[OP_CB_READ:OP_BUF_READ]} |=>
    state_q == S_POLL_CMD ##1 state_q == S_POLL_CMD && pend_q)
    else $error("open cache run not polled first");
  pair_refuse_a: assert property (
    state_q == S_IDLE && start && mismatch &&
    new_op inside {OP_CACHE, OP_MP_CACHE} |=>
    state_q == S_IDLE && err_q [*2])
    else $error("cache run left its block pair");
  busy_hold_a: assert property (
    state_q == S_WAIT_RB && !ready_busy_n_pin |=>
    state_q == S_WAIT_RB && !go_q)
    else $error("left busy wait while device busy");

  mp_second_c: cover property ($rose(second_q));
  poll_c: cover property (state_q == S_POLL_RD && poll_q && eng_done);
  refuse_c: cover property ($rose(err_q));
  buf_read_c: cover property (state_q == S_BUF_RD && eng_done);

endmodule

// [nand_host_pkg.sv]
// constants, types and register map of the nand program host controller
// assumes a 10 MHz hclk and one x8 nand die on an asynchronous bus
package nand_host_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_NS = 100;
  localparam int T_STROBE_NS = 100;
  localparam int T_HOLD_NS = 100;
  localparam int T_WB_NS = 200;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

  // ***************************************************************
  // nand commands and address layout
  // ***************************************************************
  localparam logic [7:0] CMD_LOAD = 8'h80;
  localparam logic [7:0] CMD_LOAD2 = 8'h81;
  localparam logic [7:0] CMD_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_DUMMY = 8'h11;
  localparam logic [7:0] CMD_CACHE = 8'h15;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_CB_READ = 8'h35;
  localparam logic [7:0] CMD_CB_LOAD = 8'h85;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam int ADDR_W = 40;
  localparam logic [2:0] ADDR_CYCLES = 3'h5;
  localparam logic [2:0] ROW_CYCLES = 3'h3;
  localparam logic [2:0] COL_CYCLES = 3'h2;
  localparam int PLANE_BIT = 22;
  localparam int PAIR_LSB = 23;
  localparam int LEN_W = 13;
  localparam int SR_ARRAY_RDY = 5;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR0_LO = 8'h04;
  localparam logic [7:0] REG_ADDR0_HI = 8'h08;
  localparam logic [7:0] REG_ADDR1_LO = 8'h0C;
  localparam logic [7:0] REG_ADDR1_HI = 8'h10;
  localparam logic [7:0] REG_LEN = 8'h14;
  localparam logic [7:0] REG_WDATA = 8'h18;
  localparam logic [7:0] REG_RDATA = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam int CTRL_ALT = 4;
  localparam int CTRL_LAST = 5;
  localparam int CTRL_PLANE = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_DREQ = 1;
  localparam int ST_RVALID = 2;
  localparam int ST_ERR = 3;
  localparam int ST_RB = 4;
  localparam int ST_CACHE = 5;
  localparam int ST_SR_LSB = 8;

  typedef enum logic [3:0] {
    OP_NONE, OP_PROG, OP_MP_PROG, OP_CACHE, OP_MP_CACHE, OP_CB_READ,
    OP_CB_PROG, OP_MP_CB_PROG, OP_STATUS, OP_STATUS_ENH, OP_BUF_READ
  } op_e;

  typedef enum logic [1:0] {CY_CMD, CY_ADDR, CY_DIN, CY_DOUT} cyc_e;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe;
  } nand_pins_s;

  localparam nand_pins_s PINS_IDLE = '{ce_n: 1'b0, cle: 1'b0, ale: 1'b0,
    we_n: 1'b1, re_n: 1'b1, wp_n: 1'b1, io_out: 8'h00, io_oe: 1'b0};

endpackage

// [nand_cycle.sv]
// one nand bus cycle: command, address, data in or data out
// assumes io_in is synchronous to hclk and settled by the strobe's end
`timescale 1ns/1ps
module nand_cycle import nand_host_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire cyc_e kind,
  input wire logic [7:0] wbyte,
  input wire logic [7:0] io_in,
  output nand_pins_s pins,
  output logic [7:0] rbyte,
  output logic done
);

  // ***************************************************************
  // strobe phases
  // ***************************************************************
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_LOW, P_HIGH} phase_e;
  phase_e phase_q;
  cyc_e kind_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= P_IDLE;
      kind_q <= CY_CMD;
      cnt_q <= '0;
      pins <= PINS_IDLE;
      rbyte <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_q)
        P_IDLE: begin
          if (go) begin
            kind_q <= kind;
            pins.cle <= (kind == CY_CMD);
            pins.ale <= (kind == CY_ADDR);
            pins.io_out <= wbyte;
            pins.io_oe <= (kind != CY_DOUT);
            phase_q <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (kind_q == CY_DOUT) begin
            pins.re_n <= 1'b0;
          end else begin
            pins.we_n <= 1'b0;
          end
          cnt_q <= STROBE_LAST;
          phase_q <= P_LOW;
        end
        P_LOW: begin
          if (cnt_q == '0) begin
            // sample just before re rises, data is surely valid
            if (kind_q == CY_DOUT) begin
              rbyte <= io_in;
            end
            pins.we_n <= 1'b1;
            pins.re_n <= 1'b1;
            cnt_q <= HOLD_LAST;
            phase_q <= P_HIGH;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        P_HIGH: begin
          if (cnt_q == '0) begin
            pins.cle <= 1'b0;
            pins.ale <= 1'b0;
            pins.io_oe <= 1'b0;
            done <= 1'b1;
            phase_q <= P_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: phase_q <= P_IDLE;
      endcase
    end
  end

endmodule

// [nand_die_model.sv]
// behavioural nand die: program, cache, copy-back and status commands
// assumes host pins change just after rising hclk
`timescale 1ns/1ps
module nand_die_model import nand_host_pkg::*; (
  input wire logic hclk,
  input wire nand_pins_s pins,
  input wire logic fail_inject,
  output logic [7:0] io_in,
  output logic ready_busy_n_pin
);
  // ********
  // command latch and busy timer
  // ********
  logic [7:0] cmd_q = 8'h00;
  logic [7:0] cnt_q = 8'h5A;
  logic [4:0] busy_q = 5'h00;
  logic we_q = 1'b1;
  logic fail_q = 1'b0;
  logic prev_q = 1'b0;
  logic open_q = 1'b0;
  logic [LEN_W-1:0] col_q = '0;
  logic rdy;
  logic [7:0] sr;
  logic [7:0] c;
  assign rdy = (busy_q == 5'h00);
  assign c = pins.io_out;
  // one combined byte, zero is pass
  assign sr = {1'b1, rdy, rdy, 3'h0, prev_q, fail_q};
  // pin low for every busy span
  assign ready_busy_n_pin = rdy;
  // status even in dummy busy; idle bus shows a moving pattern
  assign io_in = (!pins.re_n && cmd_q[7:4] == 4'h7) ? sr : cnt_q;
  always_ff @(posedge hclk) begin
    we_q <= pins.we_n;
    cnt_q <= cnt_q + 8'h01;
    if (!rdy) busy_q <= busy_q - 5'h01;
    // each load command restarts the column count
    if (pins.cle && pins.we_n && !we_q && c[7:4] == 4'h8) col_q <= '0;
    if (!pins.cle && !pins.ale && pins.io_oe && pins.we_n && !we_q) begin
      col_q <= col_q + 1'b1;
    end
    if (pins.cle && pins.we_n && !we_q && (rdy || c[7:4] == 4'h7)) begin
      cmd_q <= c;
      if (c == 8'h11 || c == 8'h35) busy_q <= 5'h03;
      // later transfers wait for the running program
      if (c == 8'h15) busy_q <= open_q ? 5'h0C : 5'h03;
      if (c == 8'h15) open_q <= 1'b1;
      // one program of all loaded pages, one fail bit
      if (c == 8'h10) busy_q <= 5'h0A;
      if (c == 8'h10) open_q <= 1'b0;
      if (c == 8'h10 || c == 8'h15) prev_q <= fail_q;
      if (c == 8'h10 || c == 8'h15) fail_q <= fail_inject;
    end
  end
endmodule

// [tb_nand_program_sequencer.sv]
// self-checking bench for the nand program sequencer
// assumes the die model on the nand pins, one ahb master here
`timescale 1ns/1ps
module tb_nand_program_sequencer;
  import nand_host_pkg::*;
  // ********
  // stimulus and checks
  // ********
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic fail_inject = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ready_busy_n_pin;
  logic [7:0] io_in;
  nand_pins_s nand_pins;
  int seed = 16;
  int n_mismatch = 0;
  int checks_done = 0;
  int k;
  logic [31:0] r;
  logic [31:0] len_r;
  int n_pop = 0;
  logic f_prev = 1'b0;
  logic f_cur = 1'b0;
  logic [7:0] ops [13] = '{8'h21, 8'h02, 8'h12, 8'h05, 8'h0A, 8'h06,
    8'h05, 8'h45, 8'h07, 8'h23, 8'h24, 8'h08, 8'h09};
  initial forever #50 hclk = ~hclk;
  nand_program_sequencer i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nand_pins(nand_pins),
    .io_in(io_in), .ready_busy_n_pin(ready_busy_n_pin));
  nand_die_model i_die (.hclk(hclk), .pins(nand_pins),
    .fail_inject(fail_inject), .io_in(io_in),
    .ready_busy_n_pin(ready_busy_n_pin));
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  function automatic logic [31:0] exp_sr();
    return {24'h0, 3'h7, 3'h0, f_prev, f_cur};
  endfunction
  // feeds data on request until the sequence ends
  task run_op(input logic [7:0] ctrl);
    fail_inject <= 1'($random(seed));
    len_r = 32'($random(seed)) & 32'h3;
    n_pop = 0;
    ahb(1'b1, REG_LEN, len_r);
    ahb(1'b1, REG_CTRL, {24'h0, ctrl});
    for (int i = 0; i < 3000; i++) begin
      ahb(1'b0, REG_STATUS, 32'h0);
      if (r[ST_DREQ] === 1'b1) begin
        ahb(1'b1, REG_WDATA, 32'($random(seed)) & 32'hFF);
      end else if (r[ST_RVALID] === 1'b1) begin
        ahb(1'b0, REG_RDATA, 32'h0);
        n_pop++;
      end else if (r[ST_BUSY] === 1'b0) break;
    end
    chk({31'h0, r[ST_BUSY]}, 32'h0);
    if (ctrl[3:0] == 4'hA) chk(n_pop, len_r);
    if (ctrl[3:0] < 4'h8 && ctrl[3:0] != 4'h5 && r[ST_ERR] === 1'b0) begin
      chk({19'h0, i_die.col_q}, len_r);
      f_prev = f_cur;
      f_cur = fail_inject;
    end
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(r & 32'h1F, 32'h10);
    ahb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    // same pair bits on both planes, the plane bit is forced anyway
    k = $random(seed);
    ahb(1'b1, REG_ADDR0_LO, 32'(k));
    ahb(1'b1, REG_ADDR1_LO, 32'(k));
    for (k = 0; k < 13; k++) begin
      run_op(ops[k]);
      if (ops[k][3:0] != 4'h5) chk({24'h0, r[15:8]}, exp_sr());
    end
    run_op(8'h03);
    chk({31'h0, r[ST_CACHE]}, 32'h1);
    run_op(8'h03);
    chk({30'h0, r[ST_CACHE], r[ST_BUSY]}, 32'h2);
    ahb(1'b1, REG_ADDR0_HI, 32'h1);
    run_op(8'h03);
    chk({31'h0, r[ST_ERR]}, 32'h1);
    ahb(1'b1, REG_ADDR0_HI, 32'h0);
    run_op(8'h08);
    chk({24'h0, r[15:8]}, exp_sr());
    chk({31'h0, r[ST_CACHE]}, 32'h0);
    run_op(8'h23);
    chk({24'h0, r[15:8]}, exp_sr());
    chk({31'h0, r[ST_CACHE]}, 32'h0);
    close_out;
  end
  initial begin
    repeat (90000) @(posedge hclk);
    n_mismatch++;
    close_out;
  end
endmodule
